/* File: bench/lam_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
module lam_spi_host (
  input wire logic start,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic sclk_pin,
  output logic cs_b_pin,
  output logic [15:0] word,
  output logic done
);
  initial
  begin
    sclk_pin = 1'b0;
    cs_b_pin = 1'b1;
    word = 16'h0000;
    done = 1'b0;
  end
  // The clock idles low and stands still between frames; a bit seen while the
  // output is not enabled counts as zero so that a missing drive cannot pass.
  always @(posedge start)
  begin
    done = 1'b0;
    cs_b_pin = 1'b0;
    #125;
    for (int i = 0; i < 16; i++)
    begin
      sclk_pin = 1'b1;
      word = {word[14:0], sdo & sdo_oe};
      #62.5;
      sclk_pin = 1'b0;
      #62.5;
    end
    cs_b_pin = 1'b1;
    done = 1'b1;
  end
endmodule : lam_spi_host
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic conv_valid = 1'b0;
  logic [3:0] conv_channel = 4'h0;
  logic [9:0] conv_result = 10'h000;
  logic acc_valid = 1'b0;
  logic [2:0] acc_kind = 3'h0;
  logic [3:0] acc_chan = 4'h0;
  logic acc_rd = 1'b0;
  logic acc_wr = 1'b0;
  logic [15:0] acc_wdata = 16'h0000;
  logic hyst_en = 1'b0;
  logic alert_active_high = 1'b1;
  logic [1:0] pin_func_alert = 2'b01;
  logic [8:0] pin_mask_zero = 9'h002;
  logic [8:0] pin_mask_one = 9'h100;
  logic general_pin_zero = 1'b0;
  logic general_pin_one = 1'b1;
  logic host_start = 1'b0;
  logic [15:0] rd_data_reg, aflag_reg, host_word;
  logic [1:0] tflag_reg;
  logic rd_valid_reg, limit_out_zero, limit_out_one, sclk_pin, cs_b_pin, sdo, sdo_oe, host_done;
  int error_cnt = 0;
  int comparisons = 0;
  lam_top lam_top_i (.core_clk(core_clk), .rst_b(rst_b), .conv_valid(conv_valid),
    .conv_channel(conv_channel), .conv_result(conv_result), .acc_valid(acc_valid),
    .acc_kind(acc_kind), .acc_chan(acc_chan), .acc_rd(acc_rd), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
    .hyst_en(hyst_en), .alert_active_high(alert_active_high),
    .pin_func_alert(pin_func_alert), .pin_mask_zero(pin_mask_zero),
    .pin_mask_one(pin_mask_one), .general_pin_zero(general_pin_zero),
    .general_pin_one(general_pin_one), .limit_out_zero(limit_out_zero),
    .limit_out_one(limit_out_one), .aflag_reg(aflag_reg), .tflag_reg(tflag_reg),
    .sclk_pin(sclk_pin), .cs_b_pin(cs_b_pin), .sdo(sdo), .sdo_oe(sdo_oe));
  lam_spi_host lam_spi_host_i (.start(host_start), .sdo(sdo), .sdo_oe(sdo_oe),
    .sclk_pin(sclk_pin), .cs_b_pin(cs_b_pin), .word(host_word), .done(host_done));
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic [2:0] k, input logic [3:0] c, input logic r, input logic w,
    input logic [15:0] wd);
    @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_kind <= k;
    acc_chan <= c;
    acc_rd <= r;
    acc_wr <= w;
    acc_wdata <= wd;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    #1;
    if (r)
      chk("rd_valid_reg", {15'h0000, rd_valid_reg}, 16'h0001);
  endtask : acc
  task automatic rdchk(input string what, input logic [2:0] k, input logic [3:0] c,
    input logic w, input logic [15:0] exp);
    acc(k, c, 1'b1, w, 16'h0000);
    chk(what, rd_data_reg, exp);
  endtask : rdchk
  task automatic conv(input logic [3:0] c, input logic [9:0] res);
    @(posedge core_clk);
    conv_valid <= 1'b1;
    conv_channel <= c;
    conv_result <= res;
    @(posedge core_clk);
    conv_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : conv
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100us;
    error_cnt++;
    $display("watchdog expired");
    results();
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    rdchk("high8", 3'h0, 4'h8, 1'b0, 16'hffc0);
    rdchk("low3", 3'h1, 4'h3, 1'b0, 16'h0000);
    rdchk("hyst5", 3'h2, 4'h5, 1'b0, 16'h0000);
    rdchk("min4", 3'h5, 4'h4, 1'b0, 16'hffc0);
    rdchk("max6", 3'h6, 4'h6, 1'b0, 16'h0000);
    rdchk("unmapped", 3'h7, 4'h0, 1'b0, 16'h0000);
    chk("pin0 idle", {15'h0000, limit_out_zero}, 16'h0000);
    chk("pin1 general", {15'h0000, limit_out_one}, 16'h0001);
    $display("test reset done");
    // Limits keep only the top ten bits of the written word.
    acc(3'h0, 4'h1, 1'b0, 1'b1, 16'h8fff);
    acc(3'h1, 4'h7, 1'b0, 1'b1, 16'h4000);
    rdchk("high1", 3'h0, 4'h1, 1'b0, 16'h8fc0);
    rdchk("high0", 3'h0, 4'h0, 1'b0, 16'hffc0);
    conv(4'h1, 10'h23f);
    chk("aflag equal", aflag_reg, 16'h0000);
    conv(4'h1, 10'h240);
    chk("aflag high1", aflag_reg, 16'h0008);
    chk("pin0 alert", {15'h0000, limit_out_zero}, 16'h0001);
    @(posedge core_clk);
    alert_active_high <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("pin0 low", {15'h0000, limit_out_zero}, 16'h0000);
    @(posedge core_clk);
    alert_active_high <= 1'b1;
    conv(4'h7, 10'h0ff);
    chk("aflag low7", aflag_reg, 16'h4008);
    conv(4'h1, 10'h100);
    chk("aflag back", aflag_reg, 16'h4000);
    chk("pin0 back", {15'h0000, limit_out_zero}, 16'h0000);
    $display("test limits done");
    acc(3'h2, 4'h1, 1'b0, 1'b1, 16'h0400);
    @(posedge core_clk);
    hyst_en <= 1'b1;
    conv(4'h1, 10'h240);
    conv(4'h1, 10'h230);
    chk("hyst hold", aflag_reg, 16'h4008);
    conv(4'h1, 10'h22f);
    chk("hyst clear", aflag_reg, 16'h4000);
    @(posedge core_clk);
    hyst_en <= 1'b0;
    $display("test hysteresis done");
    acc(3'h0, 4'h8, 1'b0, 1'b1, 16'h4000);
    @(posedge core_clk);
    pin_func_alert <= 2'b11;
    conv(4'h8, 10'h155);
    chk("tflag", {14'h0000, tflag_reg}, 16'h0002);
    chk("pin1 temp", {15'h0000, limit_out_one}, 16'h0001);
    @(posedge core_clk);
    host_start <= 1'b1;
    @(posedge core_clk);
    host_start <= 1'b0;
    for (int i = 0; i < 400 && !host_done; i++) @(posedge core_clk);
    chk("frame done", {15'h0000, host_done}, 16'h0001);
    chk("frame", host_word, 16'h5563);
    $display("test frame done");
    rdchk("aflag rc", 3'h3, 4'h0, 1'b1, 16'h4000);
    chk("aflag cleared", aflag_reg, 16'h0000);
    conv(4'h7, 10'h0ff);
    acc(3'h3, 4'h0, 1'b0, 1'b1, 16'h1234);
    chk("aflag kept", aflag_reg, 16'h4000);
    acc(3'h3, 4'h0, 1'b0, 1'b1, 16'hffff);
    chk("aflag blanket", aflag_reg, 16'h0000);
    acc(3'h4, 4'h0, 1'b0, 1'b1, 16'h0003);
    chk("tflag blanket", {14'h0000, tflag_reg}, 16'h0000);
    $display("test flags done");
    conv(4'h2, 10'h120);
    conv(4'h2, 10'h080);
    conv(4'h2, 10'h300);
    rdchk("max2", 3'h6, 4'h2, 1'b0, 16'hc000);
    rdchk("min2 rc", 3'h5, 4'h2, 1'b1, 16'h2000);
    rdchk("min2 reset", 3'h5, 4'h2, 1'b0, 16'hffc0);
    acc(3'h6, 4'h2, 1'b0, 1'b1, 16'h1234);
    rdchk("max2 reset", 3'h6, 4'h2, 1'b0, 16'h0000);
    $display("test minmax done");
    results();
  end
endmodule : testbench
`default_nettype wire

/* File: src/lam_frame_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lam_frame_if;
  logic [15:0] frame;
  logic load;
  logic busy;
  modport source (output frame, output load, input busy);
  modport sink (input frame, input load, output busy);
endinterface : lam_frame_if
`default_nettype wire

/* File: src/lam_limit_check.sv */
`timescale 1ns/1ps
`default_nettype none
module lam_limit_check (
  input wire logic [9:0] result,
  input wire logic [9:0] high,
  input wire logic [9:0] low,
  input wire logic [9:0] hyst,
  input wire logic hyst_en,
  input wire logic hi_prev,
  input wire logic lo_prev,
  output logic hi_next,
  output logic lo_next
);
  logic [10:0] res_up;
  logic [10:0] low_up;
  logic [10:0] step;

  always_comb
  begin
    step = hyst_en ? {1'b0, hyst} : 11'h000;
    res_up = {1'b0, result} + step;
    low_up = {1'b0, low} + step;
    // An active alert holds until the result is at least the step inside the limit.
    if (result > high)
      hi_next = 1'b1;
    else
      hi_next = hi_prev && (res_up > {1'b0, high});
    if (result < low)
      lo_next = 1'b1;
    else
      lo_next = lo_prev && ({1'b0, result} < low_up);
  end
endmodule : lam_limit_check
`default_nettype wire

/* File: src/lam_pkg.sv */
package lam_pkg;

  localparam int unsigned LAM_CHAN_N = 9;
  localparam logic [3:0] LAM_TEMP_CHAN = 4'h8;
  localparam int unsigned LAM_RES_W = 10;
  localparam int unsigned LAM_WORD_W = 16;
  localparam int unsigned LAM_AFLAG_W = 16;
  localparam int unsigned LAM_TFLAG_W = 2;
  localparam logic [5:0] LAM_PAD_ZERO = 6'h00;
  localparam logic [15:0] LAM_HIGH_RST = 16'hffc0;
  localparam logic [15:0] LAM_LOW_RST = 16'h0000;
  localparam logic [15:0] LAM_HYST_RST = 16'h0000;
  localparam logic [15:0] LAM_MIN_RST = 16'hffc0;
  localparam logic [15:0] LAM_MAX_RST = 16'h0000;
  localparam logic [15:0] LAM_AFLAG_CLR = 16'hffff;
  localparam logic [15:0] LAM_TFLAG_CLR = 16'h0003;
  localparam logic [4:0] LAM_FRAME_BITS = 5'h10;

  typedef enum logic [2:0] {
    LAM_KIND_HIGH = 3'h0,
    LAM_KIND_LOW = 3'h1,
    LAM_KIND_HYST = 3'h2,
    LAM_KIND_AFLAG = 3'h3,
    LAM_KIND_TFLAG = 3'h4,
    LAM_KIND_MIN = 3'h5,
    LAM_KIND_MAX = 3'h6
  } lam_kind_type;

  typedef enum logic [1:0] {
    LAM_SER_IDLE = 2'b01,
    LAM_SER_SHIFT = 2'b10
  } lam_ser_state_type;

  function automatic logic [15:0] lam_justify(input logic [9:0] value);
    return {value, LAM_PAD_ZERO};
  endfunction : lam_justify

endpackage : lam_pkg

/* File: src/lam_serial_out.sv */
`timescale 1ns/1ps
`default_nettype none
module lam_serial_out (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk_pin,
  input wire logic cs_b_pin,
  output logic sdo,
  output logic sdo_oe,
  lam_frame_if.sink fr
);
  logic sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
  logic cs_b_s1_reg, cs_b_s2_reg, cs_b_d_reg;
  logic [15:0] shift_reg;
  logic [4:0] count_reg;
  lam_pkg::lam_ser_state_type state_reg;
  logic fall;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      cs_b_s1_reg <= 1'b1;
      cs_b_s2_reg <= 1'b1;
      cs_b_d_reg <= 1'b1;
    end
    else
    begin
      sclk_s1_reg <= sclk_pin;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_d_reg <= sclk_s2_reg;
      cs_b_s1_reg <= cs_b_pin;
      cs_b_s2_reg <= cs_b_s1_reg;
      cs_b_d_reg <= cs_b_s2_reg;
    end
  end

  assign fall = sclk_d_reg && !sclk_s2_reg;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= lam_pkg::LAM_SER_IDLE;
      shift_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        lam_pkg::LAM_SER_IDLE:
        begin
          // A frame offered while one is going out is dropped, so bits never mix.
          if (fr.load)
            shift_reg <= fr.frame;
          // Only a fresh select starts a frame, so a select still held after the
          // sixteenth bit does not restart the shifter on an emptied word.
          if (cs_b_d_reg && !cs_b_s2_reg)
          begin
            state_reg <= lam_pkg::LAM_SER_SHIFT;
            count_reg <= '0;
          end
        end
        lam_pkg::LAM_SER_SHIFT:
        begin
          if (cs_b_s2_reg)
            state_reg <= lam_pkg::LAM_SER_IDLE;
          else if (fall)
          begin
            shift_reg <= {shift_reg[14:0], 1'b0};
            count_reg <= count_reg + 5'h01;
            if (count_reg == lam_pkg::LAM_FRAME_BITS - 5'h01)
              state_reg <= lam_pkg::LAM_SER_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else
    begin
      sdo <= shift_reg[15];
      sdo_oe <= (state_reg == lam_pkg::LAM_SER_SHIFT);
    end
  end

  assign fr.busy = (state_reg == lam_pkg::LAM_SER_SHIFT);

  frame_len_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_reg == lam_pkg::LAM_SER_SHIFT) |-> (count_reg < lam_pkg::LAM_FRAME_BITS))
    else $error("serial frame ran past sixteen bits");
endmodule : lam_serial_out
`default_nettype wire

/* File: src/lam_top.sv */
// What this block does
// - Limit words 16-bit, 10-bit left-justified, low six zero.
// - Reset: low, hysteresis zero; high 0xffc0.
// - Separate high and low limits per nine channels.
// - Result above high limit raises high alert.
// - Result below low limit raises low alert.
// - Hysteresis delays alert clear by N counts.
// - Alert pin asserts on selected channel violation.
// - Alert pin polarity selectable high or low.
// - Unread flags follow return in range; pin drops.
// - Frame alert bits show the temperature alert and any analog channel alert.
// - Analog and temperature flag words, high and low.
// - Flags accumulate across channels; other channels' bits are kept.
// - Bit 14 is channel 7 low, bit 3 channel 1 high.
// - Flags re-evaluated every conversion; clear when in range.
// - Read-and-write access returns flags and clears them.
// - Writing ffff or 0003 clears the flag word.
// - Read-only left-justified minimum and maximum per channel.
// - Write or read-and-write restores min/max reset value.
// - Reset: minimum 0xffc0, maximum 0x0000.
// - Result frame: 16 clocks, result, channel, two alerts.
`timescale 1ns/1ps
`default_nettype none
module lam_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic conv_valid,
  input wire logic [3:0] conv_channel,
  input wire logic [9:0] conv_result,
  input wire logic acc_valid,
  input wire logic [2:0] acc_kind,
  input wire logic [3:0] acc_chan,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [15:0] acc_wdata,
  output logic [15:0] rd_data_reg,
  output logic rd_valid_reg,
  input wire logic hyst_en,
  input wire logic alert_active_high,
  input wire logic [1:0] pin_func_alert,
  input wire logic [8:0] pin_mask_zero,
  input wire logic [8:0] pin_mask_one,
  input wire logic general_pin_zero,
  input wire logic general_pin_one,
  output logic limit_out_zero,
  output logic limit_out_one,
  output logic [15:0] aflag_reg,
  output logic [1:0] tflag_reg,
  input wire logic sclk_pin,
  input wire logic cs_b_pin,
  output logic sdo,
  output logic sdo_oe
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] high_reg [lam_pkg::LAM_CHAN_N];
  logic [15:0] low_reg [lam_pkg::LAM_CHAN_N];
  logic [15:0] hyst_reg [lam_pkg::LAM_CHAN_N];
  logic [15:0] min_reg [lam_pkg::LAM_CHAN_N];
  logic [15:0] max_reg [lam_pkg::LAM_CHAN_N];
  logic [8:0] hi_alert_reg, lo_alert_reg;
  logic [15:0] aflag_next;
  logic [1:0] tflag_next;
  logic conv_ok, acc_ok, wr_hit, rw_clear, is_temp;
  logic [15:0] cur_high, cur_low, cur_hyst, min_base, max_base;
  logic [15:0] res_word;
  logic hi_next, lo_next;
  logic aflag_clr, tflag_clr;
  logic conv_d_reg;
  logic [9:0] res_d_reg;
  logic [3:0] chan_d_reg;
  logic [15:0] frame_reg;
  logic load_reg;
  lam_pkg::lam_kind_type kind;

  lam_frame_if fr ();

  assign kind = lam_pkg::lam_kind_type'(acc_kind);
  assign conv_ok = conv_valid && (conv_channel <= lam_pkg::LAM_TEMP_CHAN);
  assign is_temp = (conv_channel == lam_pkg::LAM_TEMP_CHAN);
  assign acc_ok = acc_valid && (acc_chan <= lam_pkg::LAM_TEMP_CHAN);
  assign wr_hit = acc_ok && acc_wr;
  assign rw_clear = acc_valid && acc_rd && acc_wr;
  assign res_word = lam_pkg::lam_justify(conv_result);

  ////////////////////////////////////////////////////////////////////////////
  // Limit store; one entry per channel including temperature.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < lam_pkg::LAM_CHAN_N; i++)
      begin
        high_reg[i] <= lam_pkg::LAM_HIGH_RST;
        low_reg[i] <= lam_pkg::LAM_LOW_RST;
        hyst_reg[i] <= lam_pkg::LAM_HYST_RST;
      end
    end
    else if (wr_hit)
    begin
      // Low six bits are forced to zero whatever the writer sends.
      if (kind == lam_pkg::LAM_KIND_HIGH)
        high_reg[acc_chan] <= lam_pkg::lam_justify(acc_wdata[15:6]);
      if (kind == lam_pkg::LAM_KIND_LOW)
        low_reg[acc_chan] <= lam_pkg::lam_justify(acc_wdata[15:6]);
      if (kind == lam_pkg::LAM_KIND_HYST)
        hyst_reg[acc_chan] <= lam_pkg::lam_justify(acc_wdata[15:6]);
    end
  end

  always_comb
  begin
    cur_high = conv_ok ? high_reg[conv_channel] : lam_pkg::LAM_HIGH_RST;
    cur_low = conv_ok ? low_reg[conv_channel] : lam_pkg::LAM_LOW_RST;
    cur_hyst = conv_ok ? hyst_reg[conv_channel] : lam_pkg::LAM_HYST_RST;
  end

  lam_limit_check u_check (
    .result(conv_result),
    .high(cur_high[15:6]),
    .low(cur_low[15:6]),
    .hyst(cur_hyst[15:6]),
    .hyst_en(hyst_en),
    .hi_prev(conv_ok ? hi_alert_reg[conv_channel] : 1'b0),
    .lo_prev(conv_ok ? lo_alert_reg[conv_channel] : 1'b0),
    .hi_next(hi_next),
    .lo_next(lo_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Live alert state, governed by hysteresis, drives the pins.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hi_alert_reg <= '0;
      lo_alert_reg <= '0;
    end
    else if (conv_ok)
    begin
      hi_alert_reg[conv_channel] <= hi_next;
      lo_alert_reg[conv_channel] <= lo_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag words. The conversion is applied after the host clear so that an
  // alert arriving in the clearing cycle is not lost.
  assign aflag_clr = acc_valid && (kind == lam_pkg::LAM_KIND_AFLAG) && acc_wr
    && (acc_rd || acc_wdata == lam_pkg::LAM_AFLAG_CLR);
  assign tflag_clr = acc_valid && (kind == lam_pkg::LAM_KIND_TFLAG) && acc_wr
    && (acc_rd || acc_wdata == lam_pkg::LAM_TFLAG_CLR);

  always_comb
  begin
    aflag_next = aflag_clr ? '0 : aflag_reg;
    tflag_next = tflag_clr ? '0 : tflag_reg;
    if (conv_ok && !is_temp)
    begin
      aflag_next[{conv_channel[2:0], 1'b0}] = lo_next;
      aflag_next[{conv_channel[2:0], 1'b1}] = hi_next;
    end
    if (conv_ok && is_temp)
    begin
      tflag_next[0] = lo_next;
      tflag_next[1] = hi_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aflag_reg <= '0;
      tflag_reg <= '0;
    end
    else
    begin
      aflag_reg <= aflag_next;
      tflag_reg <= tflag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Minimum and maximum tracking; a restore and a conversion in the same
  // cycle on the same channel count the conversion against the reset value.
  always_comb
  begin
    min_base = conv_ok ? min_reg[conv_channel] : lam_pkg::LAM_MIN_RST;
    max_base = conv_ok ? max_reg[conv_channel] : lam_pkg::LAM_MAX_RST;
    if (wr_hit && acc_chan == conv_channel && kind == lam_pkg::LAM_KIND_MIN)
      min_base = lam_pkg::LAM_MIN_RST;
    if (wr_hit && acc_chan == conv_channel && kind == lam_pkg::LAM_KIND_MAX)
      max_base = lam_pkg::LAM_MAX_RST;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < lam_pkg::LAM_CHAN_N; i++)
      begin
        min_reg[i] <= lam_pkg::LAM_MIN_RST;
        max_reg[i] <= lam_pkg::LAM_MAX_RST;
      end
    end
    else
    begin
      if (wr_hit && kind == lam_pkg::LAM_KIND_MIN)
        min_reg[acc_chan] <= lam_pkg::LAM_MIN_RST;
      if (wr_hit && kind == lam_pkg::LAM_KIND_MAX)
        max_reg[acc_chan] <= lam_pkg::LAM_MAX_RST;
      if (conv_ok && res_word < min_base)
        min_reg[conv_channel] <= res_word;
      if (conv_ok && res_word > max_base)
        max_reg[conv_channel] <= res_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port. The old value is returned even when the access also clears it.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data_reg <= '0;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      rd_valid_reg <= acc_valid && acc_rd;
      if (acc_valid && acc_rd)
      begin
        rd_data_reg <= '0;
        case (kind)
          lam_pkg::LAM_KIND_AFLAG: rd_data_reg <= aflag_reg;
          lam_pkg::LAM_KIND_TFLAG: rd_data_reg <= {14'h0000, tflag_reg};
          default:
          begin
            if (acc_ok)
            begin
              unique case (kind)
                lam_pkg::LAM_KIND_HIGH: rd_data_reg <= high_reg[acc_chan];
                lam_pkg::LAM_KIND_LOW: rd_data_reg <= low_reg[acc_chan];
                lam_pkg::LAM_KIND_HYST: rd_data_reg <= hyst_reg[acc_chan];
                lam_pkg::LAM_KIND_MIN: rd_data_reg <= min_reg[acc_chan];
                lam_pkg::LAM_KIND_MAX: rd_data_reg <= max_reg[acc_chan];
                default: rd_data_reg <= '0;
              endcase
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert pins follow the hysteresis state, not the host-clearable flags, so a
  // flag clear leaves them up; they drop once the signal is back in range.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      limit_out_zero <= 1'b0;
      limit_out_one <= 1'b0;
    end
    else
    begin
      if (pin_func_alert[0])
        limit_out_zero <= (|((hi_alert_reg | lo_alert_reg) & pin_mask_zero)) ~^
          alert_active_high;
      else
        limit_out_zero <= general_pin_zero;
      if (pin_func_alert[1])
        limit_out_one <= (|((hi_alert_reg | lo_alert_reg) & pin_mask_one)) ~^
          alert_active_high;
      else
        limit_out_one <= general_pin_one;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result frame is built one cycle after the conversion, from updated state.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      conv_d_reg <= 1'b0;
      res_d_reg <= '0;
      chan_d_reg <= '0;
      frame_reg <= '0;
      load_reg <= 1'b0;
    end
    else
    begin
      conv_d_reg <= conv_ok;
      if (conv_ok)
      begin
        res_d_reg <= conv_result;
        chan_d_reg <= conv_channel;
      end
      load_reg <= conv_d_reg && !fr.busy;
      if (conv_d_reg)
        frame_reg <= {res_d_reg, chan_d_reg, hi_alert_reg[8] | lo_alert_reg[8],
          |(hi_alert_reg[7:0] | lo_alert_reg[7:0])};
    end
  end

  assign fr.frame = frame_reg;
  assign fr.load = load_reg;

  lam_serial_out u_ser (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sclk_pin(sclk_pin),
    .cs_b_pin(cs_b_pin),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .fr(fr)
  );

  ////////////////////////////////////////////////////////////////////////////
  limit_pad_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_hit && kind == lam_pkg::LAM_KIND_HIGH |=>
    high_reg[$past(acc_chan)] == {$past(acc_wdata[15:6]), lam_pkg::LAM_PAD_ZERO})
    else $error("high limit not stored left-justified");
  high_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_ok && conv_result > cur_high[15:6] |=> hi_alert_reg[$past(conv_channel)])
    else $error("high alert missing");
  low_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_ok && conv_result < cur_low[15:6] |=> lo_alert_reg[$past(conv_channel)])
    else $error("low alert missing");
  hyst_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_ok && hyst_en && hi_alert_reg[conv_channel] &&
    ({1'b0, conv_result} + {1'b0, cur_hyst[15:6]} > {1'b0, cur_high[15:6]})
    |=> hi_alert_reg[$past(conv_channel)])
    else $error("high alert cleared inside hysteresis band");
  pin_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_ok && pin_func_alert[0] && pin_mask_zero[conv_channel] && hi_next
    && $stable(pin_func_alert) && $stable(alert_active_high)
    ##1 $stable(alert_active_high) && pin_func_alert[0] && $stable(pin_mask_zero)
    |=> limit_out_zero == $past(alert_active_high))
    else $error("alert pin not at its active level");
  flag_map_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_ok && conv_channel == 4'h7 && lo_next |=> aflag_reg[14])
    else $error("channel 7 low flag not at bit 14");
  flag_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_ok && !is_temp && !tflag_clr |=> tflag_reg == $past(tflag_reg))
    else $error("temperature flags disturbed by analog conversion");
  flag_blank_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    aflag_clr && !conv_ok |=> aflag_reg == 16'h0000)
    else $error("analog flags not cleared");
  min_track_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_ok && res_word < min_base |=> min_reg[$past(conv_channel)] == $past(res_word))
    else $error("minimum not updated");
  max_restore_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_hit && kind == lam_pkg::LAM_KIND_MAX && !conv_ok
    |=> max_reg[$past(acc_chan)] == lam_pkg::LAM_MAX_RST)
    else $error("maximum not restored by write");

  high_alert_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    conv_ok && hi_next ##[1:20] conv_ok && !hi_next);
  rw_clear_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    rw_clear && kind == lam_pkg::LAM_KIND_AFLAG && aflag_reg != 16'h0000);
  frame_out_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    load_reg ##[1:400] sdo_oe);

endmodule : lam_top
`default_nettype wire
